// >>> verilog/aed_pkg.sv
// Constants for the inertial event debounce and vector-magnitude block.
// Assumes one 40 MHz core clock and byte-wide register accesses by address.
// How it works
// - Eight-bit freefall/motion debounce count register.
// - Event flag sets when counter equals count.
// - Counter saturates at the programmed count.
// - Counter advances once per rate-dependent step.
// - Hybrid mode doubles the freefall/motion debounce step; the vector counter is unaffected.
// - Mode bit chooses decrement or clear.
// - Vector event when distance exceeds threshold long enough.
// - Reference vector is never readable by host.
// - Unlatched flag follows debounced condition both ways.
// - Latched flag holds until interrupt source read.
// - Enable captures live outputs as reference.
// - Init mode loads reference from registers.
// - Trigger replaces reference unless hold set.
// - Hold keeps reference from enable time.
// - Init plus hold: register writes apply immediately.
// - Function runs only while enable bit set.
// - Threshold is thirteen-bit unsigned, two registers.
// - Below threshold: decrement or clear vector counter.
// - Vector debounce counts whole sample periods.
// - Initial references are signed fourteen-bit values.
package aed_pkg;

  localparam logic [7:0] ADDR_INT_SOURCE = 8'h0c;
  localparam logic [7:0] ADDR_MOTION_DEBOUNCE_COUNT = 8'h18;
  localparam logic [7:0] ADDR_VECTOR_CHANGE_CONFIG = 8'h5f;
  localparam logic [7:0] ADDR_VECTOR_INIT_Z_LO = 8'h68;
  localparam int NUM_REGS = 11;
  localparam int IDX_COUNT = 0;
  localparam int IDX_CFG = 1;
  localparam int IDX_THS_HI = 2;
  localparam int IDX_THS_LO = 3;
  localparam int IDX_VCNT = 4;
  localparam int IDX_INIT = 5;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam int CFG_LATCH_BIT = 6;
  localparam int CFG_INIT_BIT = 5;
  localparam int CFG_HOLD_BIT = 4;
  localparam int CFG_EN_BIT = 3;
  localparam int THS_DBMODE_BIT = 7;

  localparam int CLK_PERIOD_NS = 25;
  localparam int STEP_BASE_NS = 1250000;
  localparam int STEP_BASE_CYCLES = STEP_BASE_NS / CLK_PERIOD_NS;

  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_LOW_POWER_LOW_NOISE = 2'h1;
  localparam logic [1:0] PWR_HIGHRES = 2'h2;
  localparam logic [1:0] PWR_LOWPOWER = 2'h3;

  // Step length as a power of two of the 1.25 ms base, per data rate code.
  localparam logic [3:0] ODR_STEP_SHIFT [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h9};
  localparam logic [3:0] CAP_NORMAL = 4'h4;
  localparam logic [3:0] CAP_LOW_POWER_LOW_NOISE = 4'h6;
  localparam logic [3:0] CAP_HIGHRES = 4'h1;
  localparam logic [3:0] CAP_LOWPOWER = 4'h7;

endpackage

// >>> verilog/aed_event_debounce.sv
// Freefall/motion debounce counter and accelerometer vector-magnitude change detector.
// Assumes one core clock, synchronous inputs, and a one-cycle sample strobe from the data path.
`timescale 1ns/1ps
`default_nettype none

module aed_event_debounce
  import aed_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = STEP_BASE_CYCLES
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Sample path
  input wire logic sampleValid,
  input wire logic signed [13:0] accelX,
  input wire logic signed [13:0] accelY,
  input wire logic signed [13:0] accelZ,
  input wire logic ffmtCondition,
  input wire logic ffmtDebounceMode,
  // Rate and power mode
  input wire logic [2:0] odrSel,
  input wire logic [1:0] powerMode,
  input wire logic hybridMode,
  // Event flags
  output logic ffmtEvent,
  output logic vecmEvent
);

  localparam int BW = $clog2(STEP_CYCLES + 1);

  if (STEP_CYCLES < 1)
  begin : gBadStep
    $error("STEP_CYCLES must be at least one");
  end

  // Register file.
  logic [7:0] regQ [NUM_REGS], regD [NUM_REGS];
  logic [7:0] rdDataQ, rdDataD;
  logic regHit;
  logic [3:0] regIdx;

  always_comb
  begin
    regHit = 1'b0;
    regIdx = 4'h0;
    if (regAddr == ADDR_MOTION_DEBOUNCE_COUNT)
    begin
      regHit = 1'b1;
    end
    else if (regAddr >= ADDR_VECTOR_CHANGE_CONFIG && regAddr <= ADDR_VECTOR_INIT_Z_LO)
    begin
      regHit = 1'b1;
      regIdx = 4'(regAddr - ADDR_VECTOR_CHANGE_CONFIG + 8'h01);
    end
  end

  always_comb
  begin
    regD = regQ;
    rdDataD = rdDataQ;
    if (regWrEn && regHit)
    begin
      regD[regIdx] = regWrData;
    end
    // The reference vector has no address, so it can never be read back.
    if (regRdEn)
    begin
      rdDataD = regHit ? regQ[regIdx] : 8'h00;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regQ <= '{default: REG_RESET};
      rdDataQ <= REG_RESET;
    end
    else
    begin
      regQ <= regD;
      rdDataQ <= rdDataD;
    end
  end

  assign regRdData = rdDataQ;

  logic [7:0] ffmtCount;
  logic vecEn, vecLatch, vecInitMode, vecHold, vecDbMode;
  logic [12:0] vecThs;
  logic [7:0] vecCount;
  assign ffmtCount = regQ[IDX_COUNT];
  assign vecEn = regQ[IDX_CFG][CFG_EN_BIT];
  assign vecLatch = regQ[IDX_CFG][CFG_LATCH_BIT];
  assign vecInitMode = regQ[IDX_CFG][CFG_INIT_BIT];
  assign vecHold = regQ[IDX_CFG][CFG_HOLD_BIT];
  assign vecDbMode = regQ[IDX_THS_HI][THS_DBMODE_BIT];
  assign vecThs = {regQ[IDX_THS_HI][4:0], regQ[IDX_THS_LO]};
  assign vecCount = regQ[IDX_VCNT];

  // Debounce time step divider.
  logic [BW-1:0] baseCntQ, baseCntD;
  logic [10:0] multCntQ, multCntD;
  logic [3:0] rateShift, capShift, stepShift;
  logic baseTick, stepTick;

  always_comb
  begin
    rateShift = ODR_STEP_SHIFT[odrSel];
    unique case (powerMode)
      PWR_NORMAL: capShift = CAP_NORMAL;
      PWR_LOW_POWER_LOW_NOISE: capShift = CAP_LOW_POWER_LOW_NOISE;
      PWR_HIGHRES: capShift = CAP_HIGHRES;
      PWR_LOWPOWER: capShift = CAP_LOWPOWER;
    endcase
    stepShift = (rateShift > capShift) ? capShift : rateShift;
    stepShift = stepShift + {3'h0, hybridMode};
    baseTick = (baseCntQ == BW'(STEP_CYCLES - 1));
    stepTick = baseTick && (multCntQ == (11'h001 << stepShift) - 11'h001);
    baseCntD = baseTick ? '0 : baseCntQ + BW'(1);
    multCntD = multCntQ;
    if (stepTick)
    begin
      multCntD = 11'h000;
    end
    else if (baseTick)
    begin
      multCntD = multCntQ + 11'h001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      baseCntQ <= '0;
      multCntQ <= 11'h000;
    end
    else
    begin
      baseCntQ <= baseCntD;
      multCntQ <= multCntD;
    end
  end

  // Freefall/motion debounce counter.
  logic ffmtCondQ, ffmtCondD;
  logic [7:0] ffmtCntQ, ffmtCntD;
  logic ffmtEventQ, ffmtEventD;

  always_comb
  begin
    ffmtCondD = sampleValid ? ffmtCondition : ffmtCondQ;
    ffmtCntD = ffmtCntQ;
    ffmtEventD = ffmtEventQ;
    if (stepTick)
    begin
      if (ffmtCondQ)
      begin
        ffmtCntD = (ffmtCntQ < ffmtCount) ? ffmtCntQ + 8'h01 : ffmtCount;
      end
      else if (ffmtDebounceMode)
      begin
        ffmtCntD = 8'h00;
      end
      else if (ffmtCntQ != 8'h00)
      begin
        ffmtCntD = ffmtCntQ - 8'h01;
      end
      ffmtEventD = ffmtCondQ && (ffmtCntD == ffmtCount);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ffmtCondQ <= 1'b0;
      ffmtCntQ <= 8'h00;
      ffmtEventQ <= 1'b0;
    end
    else
    begin
      ffmtCondQ <= ffmtCondD;
      ffmtCntQ <= ffmtCntD;
      ffmtEventQ <= ffmtEventD;
    end
  end

  assign ffmtEvent = ffmtEventQ;

  // Vector-magnitude change detector.
  logic signed [13:0] accel [3];
  logic signed [13:0] initVal [3];
  logic signed [13:0] refQ [3], refD [3], loadVal [3];
  logic [29:0] sq [3];
  logic [31:0] distSq;
  logic [25:0] thsSq;
  logic above, enPrevQ, enRise, trigger, clearRead;
  logic [7:0] vecCntQ, vecCntD;
  logic vecEventQ, vecEventD;

  assign accel[0] = accelX;
  assign accel[1] = accelY;
  assign accel[2] = accelZ;

  for (genvar a = 0; a < 3; a++)
  begin : gAxis
    logic signed [14:0] diff;
    assign initVal[a] = {regQ[IDX_INIT + 2 * a][5:0], regQ[IDX_INIT + 2 * a + 1]};
    assign loadVal[a] = vecInitMode ? initVal[a] : accel[a];
    assign diff = 15'(accel[a]) - 15'(refQ[a]);
    assign sq[a] = 30'(diff * diff);
  end

  assign distSq = 32'(sq[0]) + 32'(sq[1]) + 32'(sq[2]);
  assign thsSq = 26'(vecThs * vecThs);
  assign above = distSq > {6'h00, thsSq};
  assign enRise = vecEn && !enPrevQ;
  assign trigger = vecEn && sampleValid && above && (vecCntQ >= vecCount);
  assign clearRead = regRdEn && (regAddr == ADDR_INT_SOURCE);

  always_comb
  begin
    refD = refQ;
    if (enRise)
    begin
      refD = loadVal;
    end
    else if (vecEn && vecInitMode && vecHold)
    begin
      refD = initVal;
    end
    else if (trigger && !vecHold)
    begin
      refD = accel;
    end
  end

  always_comb
  begin
    vecCntD = vecCntQ;
    vecEventD = vecEventQ;
    if (!vecEn)
    begin
      vecCntD = 8'h00;
    end
    else if (sampleValid)
    begin
      if (above)
      begin
        vecCntD = (vecCntQ < vecCount) ? vecCntQ + 8'h01 : vecCount;
      end
      else if (vecDbMode)
      begin
        vecCntD = 8'h00;
      end
      else if (vecCntQ != 8'h00)
      begin
        vecCntD = vecCntQ - 8'h01;
      end
    end
    if (vecLatch)
    begin
      // A trigger in the same cycle as the clearing read wins.
      vecEventD = trigger || (vecEventQ && !clearRead);
    end
    else if (!vecEn)
    begin
      vecEventD = 1'b0;
    end
    else if (sampleValid)
    begin
      vecEventD = trigger || (vecEventQ && vecCntD != 8'h00);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refQ <= '{default: '0};
      enPrevQ <= 1'b0;
      vecCntQ <= 8'h00;
      vecEventQ <= 1'b0;
    end
    else
    begin
      refQ <= refD;
      enPrevQ <= vecEn;
      vecCntQ <= vecCntD;
      vecEventQ <= vecEventD;
    end
  end

  assign vecmEvent = vecEventQ;

  chk_ffmt_saturate: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(ffmtCntQ) && $past(ffmtCondQ) |-> ffmtCntQ <= ffmtCount)
    else $error("Motion debounce counter passed its count.");
  chk_ffmt_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(ffmtEventQ) |-> ffmtCntQ == ffmtCount && $past(stepTick))
    else $error("Motion event set away from the count.");
  chk_ffmt_step_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(ffmtCntQ) |-> $past(stepTick))
    else $error("Motion counter moved off a time step.");
  chk_vecm_disabled: assert property (@(posedge core_clk) disable iff (!rst_n)
    !vecEn |=> vecCntQ == 8'h00)
    else $error("Vector counter ran while disabled.");
  chk_vecm_latch_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    vecLatch && vecEventQ && !clearRead ##1 vecLatch |-> vecEventQ)
    else $error("Latched vector flag dropped without a read.");
  chk_vecm_read_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    vecLatch && clearRead && !trigger |=> !vecEventQ)
    else $error("Interrupt source read did not clear the flag.");
  chk_vecm_dbclear: assert property (@(posedge core_clk) disable iff (!rst_n)
    vecEn && vecDbMode && sampleValid && !above |=> vecCntQ == 8'h00)
    else $error("Vector counter not cleared below threshold.");
  chk_ref_init_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    enRise && vecInitMode |=> refQ[0] == $past(initVal[0]) && refQ[2] == $past(initVal[2]))
    else $error("Reference not loaded from initial values.");
  chk_ref_trig_update: assert property (@(posedge core_clk) disable iff (!rst_n)
    trigger && !vecHold && !enRise |=> refQ[1] == $past(accelY))
    else $error("Reference not replaced on trigger.");

endmodule

`default_nettype wire

// >>> testbench/aed_host_model.sv
// Host processor model: byte writes and reads on the register port.
// Assumes the bench calls its tasks; every change lands on a falling edge.
`timescale 1ns/1ps
`default_nettype none
module aed_host_model
(
  // Clock
  input wire logic core_clk,
  // Register port
  output logic regWrEn,
  output logic regRdEn,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData
);
  initial
  begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end

  // Run-time writes to the initial-value registers move the reference only while enable, init and hold bits are all set.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge core_clk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask

  // Reading the event source address clears a latched vector flag.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge core_clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    @(negedge core_clk);
    d = regRdData;
  endtask
endmodule
`default_nettype wire

// >>> testbench/test_aed_event_debounce.sv
// Bench for the event debounce block: register rows, then hand-written event cases.
// Assumes the host model drives the register port and the bench the sample path.
`timescale 1ns/1ps
`default_nettype none
module test_aed_event_debounce;
  import aed_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic regWrEn, regRdEn, ffmtEvent, vecmEvent;
  logic [7:0] regAddr, regWrData, regRdData, rdVal;
  logic sampleValid = 1'b0;
  logic signed [13:0] accelX = 14'sh0, accelY = 14'sh0, accelZ = 14'sh0;
  logic [1:0] powerMode = PWR_NORMAL;
  logic ffmtCondition = 1'b0;
  logic ffmtDebounceMode = 1'b1;
  logic [2:0] odrSel = 3'h0;
  logic hybridMode = 1'b0;
  int errCount = 0;
  int nCompared = 0;
  int cyc = 0;
  logic [7:0] rowA [12] = '{8'h18, 8'h5f, 8'h60, 8'h61, 8'h62, 8'h63, 8'h68, 8'h70, 8'h0c, 8'h60, 8'h63, 8'h68};
  logic [7:0] rowD [12] = '{8'ha5, 8'h07, 8'h9f, 8'h64, 8'h02, 8'h3f, 8'h81, 8'h55, 8'hff, 8'h80, 8'h00, 8'h00};
  logic [7:0] rowE [12] = '{8'ha5, 8'h07, 8'h9f, 8'h64, 8'h02, 8'h3f, 8'h81, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};

  always #12.5 core_clk = ~core_clk;

  aed_event_debounce #(.STEP_CYCLES(4)) u_aed_event_debounce (
    .core_clk(core_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .sampleValid(sampleValid), .accelX(accelX),
    .accelY(accelY), .accelZ(accelZ), .ffmtCondition(ffmtCondition), .ffmtDebounceMode(ffmtDebounceMode),
    .odrSel(odrSel), .powerMode(powerMode), .hybridMode(hybridMode), .ffmtEvent(ffmtEvent),
    .vecmEvent(vecmEvent));

  aed_host_model u_aed_host_model (
    .core_clk(core_clk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData));

  task automatic chkByte(input string n, input logic [7:0] e, input logic [7:0] g);
    nCompared++;
    if (g !== e)
    begin
      errCount++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkBit(input string n, input logic e, input logic g);
    chkByte(n, {7'h0, e}, {7'h0, g});
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    u_aed_host_model.rd(a, rdVal);
    chkByte("regRdData", e, rdVal);
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic smp(input logic signed [13:0] x, input logic c);
    @(negedge core_clk);
    accelX = x;
    ffmtCondition = c;
    sampleValid = 1'b1;
    @(negedge core_clk);
    sampleValid = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic endTest(input string n);
    $display("test %s done", n);
  endtask

  task automatic stopTest();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errCount++;
      stopTest();
    end
  end

  initial
  begin
    wt(10);
    rst_n = 1'b1;
    rdChk(8'h18, 8'h00);
    rdChk(8'h5f, 8'h00);
    chkBit("ffmtEvent", 1'b0, ffmtEvent);
    for (int i = 0; i < 12; i++)
    begin
      u_aed_host_model.wr(rowA[i], rowD[i]);
      rdChk(rowA[i], rowE[i]);
    end
    endTest("registers");
    u_aed_host_model.wr(8'h18, 8'h03);
    smp(14'sd0, 1'b0);
    wt(8);
    smp(14'sd0, 1'b1);
    wt(3);
    chkBit("ffmtEvent", 1'b0, ffmtEvent);
    wt(10);
    chkBit("ffmtEvent", 1'b1, ffmtEvent);
    wt(20);
    chkBit("ffmtEvent", 1'b1, ffmtEvent);
    smp(14'sd0, 1'b0);
    wt(6);
    chkBit("ffmtEvent", 1'b0, ffmtEvent);
    hybridMode = 1'b1;
    smp(14'sd0, 1'b1);
    wt(12);
    chkBit("ffmtEvent", 1'b0, ffmtEvent);
    wt(20);
    chkBit("ffmtEvent", 1'b1, ffmtEvent);
    smp(14'sd0, 1'b0);
    wt(10);
    hybridMode = 1'b0;
    endTest("freefall debounce");
    odrSel = 3'h1;
    u_aed_host_model.wr(8'h5f, 8'h38);
    smp(14'sd100, 1'b0);
    smp(14'sd101, 1'b0);
    smp(14'sd101, 1'b0);
    chkBit("vecmEvent", 1'b0, vecmEvent);
    smp(14'sd101, 1'b0);
    chkBit("vecmEvent", 1'b1, vecmEvent);
    smp(14'sd101, 1'b0);
    chkBit("vecmEvent", 1'b1, vecmEvent);
    smp(14'sd0, 1'b0);
    chkBit("vecmEvent", 1'b0, vecmEvent);
    u_aed_host_model.wr(8'h64, 8'h65);
    repeat (3) smp(14'sd101, 1'b0);
    chkBit("vecmEvent", 1'b0, vecmEvent);
    u_aed_host_model.wr(8'h64, 8'h00);
    u_aed_host_model.wr(8'h60, 8'h00);
    repeat (3) smp(14'sd101, 1'b0);
    smp(14'sd0, 1'b0);
    chkBit("vecmEvent", 1'b1, vecmEvent);
    smp(14'sd0, 1'b0);
    chkBit("vecmEvent", 1'b0, vecmEvent);
    u_aed_host_model.wr(8'h5f, 8'h30);
    repeat (4) smp(14'sd101, 1'b0);
    chkBit("vecmEvent", 1'b0, vecmEvent);
    endTest("vector unlatched");
    u_aed_host_model.wr(8'h60, 8'h80);
    u_aed_host_model.wr(8'h5f, 8'h78);
    repeat (3) smp(14'sd101, 1'b0);
    smp(14'sd0, 1'b0);
    chkBit("vecmEvent", 1'b1, vecmEvent);
    rdChk(8'h0c, 8'h00);
    chkBit("vecmEvent", 1'b0, vecmEvent);
    u_aed_host_model.wr(8'h5f, 8'h00);
    smp(14'sd300, 1'b0);
    u_aed_host_model.wr(8'h5f, 8'h08);
    repeat (3) smp(14'sd300, 1'b0);
    chkBit("vecmEvent", 1'b0, vecmEvent);
    repeat (3) smp(14'sd0, 1'b0);
    chkBit("vecmEvent", 1'b1, vecmEvent);
    smp(14'sd0, 1'b0);
    chkBit("vecmEvent", 1'b0, vecmEvent);
    endTest("vector latch and reference");
    accelY = 14'sd61;
    accelZ = 14'sd80;
    repeat (3) smp(14'sd0, 1'b0);
    chkBit("vecmEvent", 1'b1, vecmEvent);
    smp(14'sd0, 1'b0);
    chkBit("vecmEvent", 1'b0, vecmEvent);
    endTest("vector three axes");
    ffmtDebounceMode = 1'b0;
    smp(14'sd0, 1'b1);
    wt(30);
    chkBit("ffmtEvent", 1'b1, ffmtEvent);
    smp(14'sd0, 1'b0);
    wt(5);
    smp(14'sd0, 1'b1);
    wt(10);
    chkBit("ffmtEvent", 1'b1, ffmtEvent);
    ffmtDebounceMode = 1'b1;
    smp(14'sd0, 1'b0);
    wt(10);
    odrSel = 3'h3;
    powerMode = PWR_HIGHRES;
    smp(14'sd0, 1'b1);
    wt(24);
    chkBit("ffmtEvent", 1'b1, ffmtEvent);
    endTest("freefall modes");
    rst_n = 1'b0;
    wt(2);
    rst_n = 1'b1;
    rdChk(8'h18, 8'h00);
    rdChk(8'h5f, 8'h00);
    chkBit("ffmtEvent", 1'b0, ffmtEvent);
    endTest("second reset");
    stopTest();
  end
endmodule
`default_nettype wire
